// *** hw/prsq_device.sv ***
// Memory device end: self-initialisation, refresh and hardware reset
`timescale 1ns/1ps
`default_nettype none
// Function
// - Self-initialisation done within init wait
// - Host keeps select high during init
// - Init wait starts after reset pin high
// - Host issues no transaction during init
// - Refresh array rows during init wait
// - Reset pin low returns to standby; prsq_device holds standby low from PRSQ_RESET until PRSQ_INIT ends
// - Reset restores configuration to defaults
// - Self-refresh halted while reset low
// - Reset returns refresh row counter default
// - Host treats array as lost after reset
// - Host idle during reset and spacing
// - Reset pulse and release spacing minimums
// - Reset assert to select spacing minimum
// - Host resets after shallow supply dip; prsq_host has no supply input and resets only on rstn and reset_req
module prsq_device #(
  parameter int unsigned INIT_CYC = prsq_pkg::INIT_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_good,
  prsq_if.device link,
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_wdata,
  output logic ready,
  output logic standby,
  output logic busy,
  output logic refresh_pulse,
  output logic [12:0] refresh_row,
  output logic [15:0] cfg_value,
  output logic access_violation
);
  typedef enum logic [1:0] {
    PRSQ_OFF, PRSQ_RESET, PRSQ_INIT, PRSQ_READY
  } prsq_dev_state_e;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: change counts when stages two and three agree
  logic [2:0] rst_sync_reg;
  logic [2:0] sel_sync_reg;
  logic [2:0] pg_sync_reg;
  logic rst_q_reg;
  logic sel_q_reg;
  logic pg_q_reg;
  logic rst_q_next;
  logic sel_q_next;
  logic pg_q_next;

  always_comb begin
    rst_q_next = rst_q_reg;
    sel_q_next = sel_q_reg;
    pg_q_next = pg_q_reg;
    if (rst_sync_reg[1] == rst_sync_reg[2]) begin
      rst_q_next = rst_sync_reg[2];
    end
    if (sel_sync_reg[1] == sel_sync_reg[2]) begin
      sel_q_next = sel_sync_reg[2];
    end
    if (pg_sync_reg[1] == pg_sync_reg[2]) begin
      pg_q_next = pg_sync_reg[2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 3'h0;
      sel_sync_reg <= 3'h7;
      pg_sync_reg <= 3'h0;
      rst_q_reg <= 1'b0;
      sel_q_reg <= 1'b1;
      pg_q_reg <= 1'b0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], link.reset_n};
      sel_sync_reg <= {sel_sync_reg[1:0], link.select_n};
      pg_sync_reg <= {pg_sync_reg[1:0], supply_good};
      rst_q_reg <= rst_q_next;
      sel_q_reg <= sel_q_next;
      pg_q_reg <= pg_q_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer state
  prsq_dev_state_e state_reg;
  prsq_dev_state_e state_next;
  logic [prsq_pkg::CNT_W-1:0] cnt_reg;
  logic [prsq_pkg::CNT_W-1:0] cnt_next;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic [12:0] row_reg;
  logic [12:0] row_next;
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic ref_reg;
  logic ref_next;
  logic viol_reg;
  logic viol_next;
  logic ready_next;
  logic standby_next;
  logic busy_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    div_next = div_reg + 2'h1;
    row_next = row_reg;
    cfg_next = cfg_reg;
    ref_next = 1'b0;
    viol_next = 1'b0;
    if (!pg_q_reg) begin
      state_next = PRSQ_OFF;
      cfg_next = prsq_pkg::CFG_DEFAULT;
      row_next = prsq_pkg::ROW_DEFAULT;
      div_next = 2'h0;
    end else if (!rst_q_reg) begin
      state_next = PRSQ_RESET;
      cfg_next = prsq_pkg::CFG_DEFAULT;
      row_next = prsq_pkg::ROW_DEFAULT;
      div_next = 2'h0;
      viol_next = !sel_q_reg;
    end else begin
      case (state_reg)
        PRSQ_OFF, PRSQ_RESET: begin
          state_next = PRSQ_INIT;
          cnt_next = '0;
        end
        PRSQ_INIT: begin
          cnt_next = cnt_reg + 16'h0001;
          viol_next = !sel_q_reg;
          if (cnt_reg == 16'(INIT_CYC - prsq_pkg::SYNC_LAG_CYC - 1)) begin
            state_next = PRSQ_READY;
          end
        end
        PRSQ_READY: begin
          if (cfg_wr && !sel_q_reg) begin
            cfg_next = cfg_wdata;
          end
        end
        default: state_next = PRSQ_OFF;
      endcase
      // Self-refresh runs while powered and out of reset
      if (div_reg == 2'(prsq_pkg::REFRESH_DIV_CYC - 1)) begin
        ref_next = 1'b1;
        row_next = row_reg + 13'h0001;
      end
    end
    ready_next = (state_next == PRSQ_READY);
    standby_next = ready_next && sel_q_next;
    busy_next = (state_next == PRSQ_INIT);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= PRSQ_OFF;
      cnt_reg <= '0;
      div_reg <= 2'h0;
      row_reg <= prsq_pkg::ROW_DEFAULT;
      cfg_reg <= prsq_pkg::CFG_DEFAULT;
      ref_reg <= 1'b0;
      viol_reg <= 1'b0;
      ready <= 1'b0;
      standby <= 1'b0;
      busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      row_reg <= row_next;
      cfg_reg <= cfg_next;
      ref_reg <= ref_next;
      viol_reg <= viol_next;
      ready <= ready_next;
      standby <= standby_next;
      busy <= busy_next;
    end
  end

  assign refresh_pulse = ref_reg;
  assign refresh_row = row_reg;
  assign cfg_value = cfg_reg;
  assign access_violation = viol_reg;
endmodule // prsq_device
`default_nettype wire

// *** hw/prsq_host.sv ***
// Host end: drives reset and select with counted spacings
`timescale 1ns/1ps
`default_nettype none
module prsq_host #(
  parameter int unsigned INIT_CYC = prsq_pkg::INIT_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  prsq_if.host link,
  input wire logic reset_req,
  input wire logic access_req,
  output logic access_ok,
  output logic data_lost
);
  typedef enum logic [2:0] {
    PRSH_PULSE, PRSH_WAIT, PRSH_INIT, PRSH_IDLE, PRSH_ACCESS
  } prsq_host_state_e;

  prsq_host_state_e state_reg;
  prsq_host_state_e state_next;
  logic [prsq_pkg::CNT_W-1:0] cnt_reg;
  logic [prsq_pkg::CNT_W-1:0] cnt_next;
  logic [prsq_pkg::CNT_W-1:0] since_reg;
  logic [prsq_pkg::CNT_W-1:0] since_next;
  logic lost_next;
  logic access_ok_next;
  logic reset_n_next;
  logic select_n_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 16'h0001;
    since_next = (since_reg == 16'hffff) ? since_reg : since_reg + 16'h0001;
    lost_next = data_lost;
    case (state_reg)
      PRSH_PULSE: begin
        since_next = 16'h0001;
        if (cnt_reg >= 16'(prsq_pkg::RESET_PULSE_CYC - 1)) begin
          state_next = PRSH_WAIT;
          cnt_next = '0;
        end
      end
      PRSH_WAIT: begin
        // Both release and assert spacings met before init wait
        if (cnt_reg >= 16'(prsq_pkg::RELEASE_SEL_CYC - 1) &&
            since_reg >= 16'(prsq_pkg::ASSERT_SEL_CYC)) begin
          state_next = PRSH_INIT;
          cnt_next = '0;
        end
      end
      PRSH_INIT: begin
        if (cnt_reg >= 16'(INIT_CYC - 1)) begin
          state_next = PRSH_IDLE;
        end
      end
      PRSH_IDLE: begin
        if (access_req) begin
          state_next = PRSH_ACCESS;
          lost_next = 1'b0;
        end
      end
      PRSH_ACCESS: begin
        if (!access_req) begin
          state_next = PRSH_IDLE;
        end
      end
      default: state_next = PRSH_PULSE;
    endcase
    // Reset request: full reset sequence
    if (reset_req) begin
      state_next = PRSH_PULSE;
      cnt_next = '0;
      lost_next = 1'b1;
    end
    access_ok_next = (state_next == PRSH_IDLE) ||
      (state_next == PRSH_ACCESS);
    reset_n_next = (state_next != PRSH_PULSE);
    select_n_next = (state_next != PRSH_ACCESS);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= PRSH_PULSE;
      cnt_reg <= '0;
      since_reg <= '0;
      data_lost <= 1'b1;
      access_ok <= 1'b0;
      link.reset_n <= 1'b0;
      link.select_n <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      since_reg <= since_next;
      data_lost <= lost_next;
      access_ok <= access_ok_next;
      link.reset_n <= reset_n_next;
      link.select_n <= select_n_next;
    end
  end
endmodule // prsq_host
`default_nettype wire

// *** pkg/prsq_if.sv ***
// Pin-level link between memory device and host sequencer
`timescale 1ns/1ps
`default_nettype none
interface prsq_if;
  logic select_n;
  logic reset_n;
  modport device (input select_n, input reset_n);
  modport host (output select_n, output reset_n);
endinterface
`default_nettype wire

// *** pkg/prsq_pkg.sv ***
// Shared constants for the pseudo-static DRAM power-up and reset sequencer
`default_nettype none
package prsq_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // Times in their own units
  localparam int unsigned INIT_WAIT_TIME_US = 150;
  localparam int unsigned RESET_PULSE_MIN_NS = 200;
  localparam int unsigned RESET_RELEASE_TO_SELECT_NS = 200;
  localparam int unsigned RESET_ASSERT_TO_SELECT_NS = 400;
  localparam int unsigned SUPPLY_LOW_DURATION_18_US = 30;
  localparam int unsigned SUPPLY_LOW_DURATION_30_US = 50;
  // Cycle counts: least times round up, longest times round down
  localparam int unsigned INIT_WAIT_CYC = INIT_WAIT_TIME_US * CLK_MHZ;
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_SEL_CYC =
    (RESET_RELEASE_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ASSERT_SEL_CYC =
    (RESET_ASSERT_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SUPPLY_LOW_18_CYC =
    SUPPLY_LOW_DURATION_18_US * CLK_MHZ;
  localparam int unsigned SUPPLY_LOW_30_CYC =
    SUPPLY_LOW_DURATION_30_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CFG_W = 16;
  localparam logic [15:0] CFG_DEFAULT = 16'h8f1f;
  localparam int unsigned ROW_W = 13;
  localparam logic [12:0] ROW_DEFAULT = 13'h0000;
  localparam int unsigned REFRESH_DIV_CYC = 4;
  localparam int unsigned SYNC_LAG_CYC = 5;
endpackage
`default_nettype wire

// *** tb/prsq_properties.sv ***
// Spacing checks on the reset and select pins
`timescale 1ns/1ps
`default_nettype none
module prsq_properties #(
  parameter int unsigned INIT_CYC = prsq_pkg::INIT_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic select_n,
  input wire logic reset_n
);
  logic [15:0] low_cnt_reg;
  logic [15:0] high_cnt_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_reg <= 16'h0;
      high_cnt_reg <= 16'h0;
    end else begin
      low_cnt_reg <= reset_n ? 16'h0 :
        low_cnt_reg + 16'(low_cnt_reg != 16'hffff);
      high_cnt_reg <= !reset_n ? 16'h0 :
        high_cnt_reg + 16'(high_cnt_reg != 16'hffff);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence sel_fall;
    $fell(select_n);
  endsequence
  sequence sel_held;
    select_n [*8];
  endsequence
  chk_boot_pulse: assert property ($rose(rstn) |-> !reset_n [*8])
    else $error("boot reset pulse short");
  chk_boot_idle: assert property ($rose(rstn) |-> sel_held)
    else $error("select low after boot");
  chk_pulse_width: assert property (
    $rose(reset_n) |-> low_cnt_reg >= prsq_pkg::RESET_PULSE_CYC)
    else $error("reset pulse short");
  chk_release_gap: assert property (
    sel_fall |-> high_cnt_reg >= prsq_pkg::RELEASE_SEL_CYC)
    else $error("select too soon after release");
  chk_assert_gap: assert property (
    $fell(reset_n) |-> sel_held ##1 sel_held)
    else $error("select too soon after reset");
  chk_init_hold: assert property (
    sel_fall |-> high_cnt_reg >= INIT_CYC)
    else $error("select during init wait");
  chk_idle_reset: assert property (!reset_n |-> select_n)
    else $error("select low in reset");
  chk_release_hold: assert property ($rose(reset_n) |-> sel_held)
    else $error("select low after release");
endmodule // prsq_properties
`default_nettype wire

// *** tb/tb_prsq.sv ***
// Self-checking bench joining host and device ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_prsq;
  localparam int unsigned INIT = 50;
  logic clk = 1'b0, rstn = 1'b0, supply_good = 1'b0, cfg_wr = 1'b0;
  logic reset_req = 1'b0, access_req = 1'b0, sel_b = 1'b1, rst_b = 1'b0;
  logic flag = 1'b0;
  logic [15:0] cfg_wdata = 16'h0, cfg_value, d, g, e;
  logic ready, standby, busy, access_ok, data_lost, viol_b, refresh_pulse;
  logic viol_a, viol_seen = 1'b0;
  logic [1:0] watch;
  logic [12:0] refresh_row;
  logic [7:0][15:0] obs;
  logic [2:0] qs[$];
  logic [15:0] qv[$];
  int fail_count = 0;
  int samples_checked = 0;
  prsq_if link();
  prsq_if link_b();
  assign link_b.select_n = sel_b;
  assign link_b.reset_n = rst_b;
  assign obs = {16'(viol_seen), 16'(flag),
    16'(refresh_row === prsq_pkg::ROW_DEFAULT),
    16'(standby), 16'(busy), 16'(ready), 16'(data_lost), cfg_value};
  assign watch = {viol_b, access_ok};
  prsq_host #(.INIT_CYC(INIT)) u_prsq_host (.clk(clk), .rstn(rstn),
    .link(link.host), .reset_req(reset_req), .access_req(access_req),
    .access_ok(access_ok), .data_lost(data_lost));
  prsq_device #(.INIT_CYC(INIT)) u_prsq_device (.clk(clk), .rstn(rstn),
    .supply_good(supply_good), .link(link.device), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .ready(ready), .standby(standby), .busy(busy),
    .refresh_pulse(refresh_pulse), .refresh_row(refresh_row),
    .cfg_value(cfg_value), .access_violation(viol_a));
  prsq_device #(.INIT_CYC(INIT)) u_prsq_device_b (.clk(clk), .rstn(rstn),
    .supply_good(supply_good), .link(link_b.device), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .ready(), .standby(), .busy(),
    .refresh_pulse(), .refresh_row(), .cfg_value(),
    .access_violation(viol_b));
  prsq_properties #(.INIT_CYC(INIT)) u_prsq_properties (.clk(clk),
    .rstn(rstn), .select_n(link.select_n), .reset_n(link.reset_n));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic note(input logic [2:0] s, input logic [15:0] v);
    qs.push_back(s);
    qv.push_back(v);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait for a level; flag tells whether it came
  task automatic await(input int k, input int n);
    while (n > 0 && watch[k] !== 1'b1) begin
      @(negedge clk);
      n--;
    end
    flag = (watch[k] === 1'b1);
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) viol_seen <= viol_seen | viol_a;
  always @(negedge clk) begin
    while (qs.size() != 0) begin
      g = obs[qs.pop_front()];
      e = qv.pop_front();
      `CHK(g, e)
    end
  end
  initial begin
    cyc(3000);
    fail_count++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hfa94));
    cyc(6);
    rstn <= 1'b1;
    cyc(2);
    supply_good <= 1'b1;
    cyc(5);
    note(3'h3, 16'h0);
    note(3'h0, prsq_pkg::CFG_DEFAULT);
    note(3'h1, 16'h1);
    await(0, INIT + 40);
    note(3'h6, 16'h1);
    note(3'h2, 16'h1);
    note(3'h5, 16'h0);
    note(3'h4, 16'h1);
    d = 16'($urandom);
    access_req <= 1'b1;
    cfg_wdata <= d;
    cyc(8);
    cfg_wr <= 1'b1;
    cyc(2);
    cfg_wr <= 1'b0;
    cyc(4);
    note(3'h0, d);
    note(3'h1, 16'h0);
    note(3'h4, 16'h0);
    access_req <= 1'b0;
    cyc(6);
    reset_req <= 1'b1;
    cyc(1);
    reset_req <= 1'b0;
    cyc(6);
    flag = 1'b0;
    repeat (4) begin
      @(negedge clk);
      flag = flag | refresh_pulse;
    end
    @(posedge clk);
    note(3'h6, 16'h0);
    note(3'h5, 16'h1);
    note(3'h0, prsq_pkg::CFG_DEFAULT);
    note(3'h2, 16'h0);
    note(3'h1, 16'h1);
    await(0, INIT + 60);
    note(3'h6, 16'h1);
    note(3'h5, 16'h0);
    for (int i = 0; i < 2; i++) begin
      rst_b <= i[0];
      cyc(10);
      sel_b <= 1'b0;
      await(1, 8);
      note(3'h6, 16'h1);
      sel_b <= 1'b1;
    end
    note(3'h7, 16'h0);
    cyc(4);
    summarize();
  end
endmodule // tb_prsq
`default_nettype wire
